// ---- core/compare_divstep_alu.sv ----
// compare, flag-clear and divide-step execution slice with its register file and flags
//
// Operation
// - flag clear forces flag zero, nothing else
// - equal compare sets flag on equality
// - signed greater-equal and greater compares
// - unsigned greater and greater-equal compares
// - single register tested against zero, signed
// - any equal byte lane sets flag
// - sign-extended immediate compared with register zero
// - failed compare clears flag, registers untouched
// - signed init loads sign bits, flag xor
// - unsigned init clears both signs and flag
// - divide step yields one quotient bit
// - save sign, shift dividend, insert flag
// - add or subtract, update sign and flag
// - no zero-divide, overflow or remainder checks
module compare_divstep_alu
  import alu_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              insn_valid,
  input  wire logic [15:0]       insn,
  input  wire reg_wr_t           reg_wr,
  input  wire logic [RIDX_W-1:0] rd_idx,
  output logic      [XLEN-1:0]   rd_data,
  output logic      [XLEN-1:0]   pc,
  output logic                   t_flag,
  output logic                   q_bit,
  output logic                   m_bit,
  output logic                   insn_done,
  output logic                   insn_bad
);

  //////////////////////////////////////////////////////////////////////////////
  // decode

  // fixed words are matched before the register forms so a full match always wins
  function automatic op_t decode(input logic [15:0] w);
    op_t o;
    o = unknown_op;
    if ((w & MASK_ALL) == OP_FLAG_CLR)       o = flag_clear_op;
    else if ((w & MASK_ALL) == OP_DIV_UINIT) o = unsigned_divide_init_op;
    else if ((w & MASK_RR) == OP_COMPARE_EQUAL_OP)     o = compare_equal_op;
    else if ((w & MASK_RR) == OP_CMP_SGE)    o = compare_signed_ge_op;
    else if ((w & MASK_RR) == OP_CMP_SGT)    o = compare_signed_gt_op;
    else if ((w & MASK_RR) == OP_CMP_UGT)    o = compare_unsigned_gt_op;
    else if ((w & MASK_RR) == OP_CMP_UGE)    o = compare_unsigned_ge_op;
    else if ((w & MASK_RN) == OP_CMP_POS)    o = compare_positive_op;
    else if ((w & MASK_RN) == OP_CMP_NNEG)   o = compare_nonnegative_op;
    else if ((w & MASK_RR) == OP_CMP_BYTE)   o = compare_byte_match_op;
    else if ((w & MASK_IMM) == OP_CMP_IMM)   o = compare_imm_equal_op;
    else if ((w & MASK_RR) == OP_DIV_SINIT)  o = signed_divide_init_op;
    else if ((w & MASK_RR) == OP_DIV_STEP)   o = divide_step_op;
    return o;
  endfunction : decode

  //////////////////////////////////////////////////////////////////////////////
  // operands and divide step

  // byte lanes of a register word, and the register the immediate compare reads
  localparam int                LANE_W   = 8;
  localparam int                LANES    = XLEN / LANE_W;
  localparam logic [RIDX_W-1:0] REG_ZERO = '0;

  state_t            st_r;
  state_t            st_nxt;
  op_t               op;
  logic [RIDX_W-1:0] dest_idx;
  logic [RIDX_W-1:0] src_idx;
  logic [XLEN-1:0]   dest_val;
  logic [XLEN-1:0]   src_val;
  logic [XLEN-1:0]   imm_ext;
  logic [XLEN-1:0]   lane_xor;
  logic [LANES-1:0]  lane_zero;
  logic [XLEN-1:0]   step_val;
  flags_t            step_flags;
  logic              hit_eq;
  logic              hit_sge;
  logic              hit_sgt;
  logic              hit_ugt;
  logic              hit_uge;
  logic              hit_pos;
  logic              hit_nneg;
  logic              hit_byte;
  logic              hit_imm;

  assign op       = decode(insn);
  assign dest_idx = insn[DEST_HI:DEST_LO];
  assign src_idx  = insn[SRC_HI:SRC_LO];
  assign dest_val = st_r.regs[dest_idx];
  assign src_val  = st_r.regs[src_idx];
  assign imm_ext  = {{(XLEN-(IMM_HI-IMM_LO+1)){insn[IMM_HI]}}, insn[IMM_HI:IMM_LO]};
  assign lane_xor = dest_val ^ src_val;

  // a lane whose xor is all zero holds the same byte in both registers
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign lane_zero[g] = (lane_xor[g*LANE_W +: LANE_W] == '0);
    end
  endgenerate

  divide_step_unit u_step (
    .dividend     (dest_val),
    .divisor      (src_val),
    .flags_in     (st_r.flags),
    .dividend_nxt (step_val),
    .flags_nxt    (step_flags)
  );

  //////////////////////////////////////////////////////////////////////////////
  // compare conditions
  // all of them are formed every cycle; the decoded operation picks one for the flag

  assign hit_eq   = (dest_val == src_val);
  assign hit_sge  = ($signed(dest_val) >= $signed(src_val));
  assign hit_sgt  = ($signed(dest_val) > $signed(src_val));
  assign hit_ugt  = (dest_val > src_val);
  assign hit_uge  = (dest_val >= src_val);
  // sign bit alone decides zero-or-positive; strictly positive also excludes zero
  assign hit_nneg = ~dest_val[XLEN-1];
  assign hit_pos  = hit_nneg && (dest_val != '0);
  assign hit_byte = |lane_zero;
  assign hit_imm  = (st_r.regs[REG_ZERO] == imm_ext);

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt        = st_r;
    st_nxt.done   = 1'b0;
    st_nxt.bad_op = 1'b0;
    // external loads land first so an instruction writing the same register wins
    if (reg_wr.en) begin
      st_nxt.regs[reg_wr.idx] = reg_wr.data;
    end
    if (insn_valid) begin
      st_nxt.done = (op != unknown_op);
      st_nxt.bad_op = (op == unknown_op);
      if (op != unknown_op) begin
        st_nxt.pc = st_r.pc + PC_STEP;
      end
      // every compare writes the flag both ways and touches no register
      case (op)
        flag_clear_op: begin
          st_nxt.flags.t = 1'b0;
        end
        compare_equal_op: begin
          st_nxt.flags.t = hit_eq;
        end
        compare_signed_ge_op: begin
          st_nxt.flags.t = hit_sge;
        end
        compare_signed_gt_op: begin
          st_nxt.flags.t = hit_sgt;
        end
        compare_unsigned_gt_op: begin
          st_nxt.flags.t = hit_ugt;
        end
        compare_unsigned_ge_op: begin
          st_nxt.flags.t = hit_uge;
        end
        compare_positive_op: begin
          st_nxt.flags.t = hit_pos;
        end
        compare_nonnegative_op: begin
          st_nxt.flags.t = hit_nneg;
        end
        compare_byte_match_op: begin
          st_nxt.flags.t = hit_byte;
        end
        compare_imm_equal_op: begin
          st_nxt.flags.t = hit_imm;
        end
        signed_divide_init_op: begin
          st_nxt.flags.q = dest_val[XLEN-1];
          st_nxt.flags.m = src_val[XLEN-1];
          st_nxt.flags.t = dest_val[XLEN-1] ^ src_val[XLEN-1];
        end
        unsigned_divide_init_op: begin
          st_nxt.flags = '0;
        end
        divide_step_op: begin
          // no zero-divisor or overflow detection; software screens operands beforehand
          st_nxt.regs[dest_idx] = step_val;
          st_nxt.flags          = step_flags;
        end
        default: begin
          // unknown words leave the flags as they were
        end
      endcase
    end
    st_nxt.rd_data = st_nxt.regs[rd_idx];
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  // clear is asynchronous; release is taken as synchronous to ref_clk

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r         <= '0;
      st_r.pc      <= PC_RESET;
      st_r.rd_data <= REG_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data   = st_r.rd_data;
  assign pc        = st_r.pc;
  assign t_flag    = st_r.flags.t;
  assign q_bit     = st_r.flags.q;
  assign m_bit     = st_r.flags.m;
  assign insn_done = st_r.done;
  assign insn_bad  = st_r.bad_op;

endmodule : compare_divstep_alu

// ---- common/alu_pkg.sv ----
// shared constants, operation codes and state layout for the compare / divide-step slice
package alu_pkg;

  localparam int          XLEN         = 32;
  localparam int          NREGS        = 16;
  localparam int          RIDX_W       = 4;

  // instruction field positions
  localparam int          DEST_HI      = 11;
  localparam int          DEST_LO      = 8;
  localparam int          SRC_HI       = 7;
  localparam int          SRC_LO       = 4;
  localparam int          IMM_HI       = 7;
  localparam int          IMM_LO       = 0;

  // opcode match patterns, compared under the mask beside them
  localparam logic [15:0] MASK_RR      = 16'hf00f;
  localparam logic [15:0] MASK_RN      = 16'hf0ff;
  localparam logic [15:0] MASK_IMM     = 16'hff00;
  localparam logic [15:0] MASK_ALL     = 16'hffff;
  localparam logic [15:0] OP_FLAG_CLR  = 16'h0008;
  localparam logic [15:0] OP_COMPARE_EQUAL_OP    = 16'h3000;
  localparam logic [15:0] OP_CMP_SGE   = 16'h3003;
  localparam logic [15:0] OP_CMP_SGT   = 16'h3007;
  localparam logic [15:0] OP_CMP_UGT   = 16'h3006;
  localparam logic [15:0] OP_CMP_UGE   = 16'h3002;
  localparam logic [15:0] OP_CMP_POS   = 16'h4015;
  localparam logic [15:0] OP_CMP_NNEG  = 16'h4011;
  localparam logic [15:0] OP_CMP_BYTE  = 16'h200c;
  localparam logic [15:0] OP_CMP_IMM   = 16'h8800;
  localparam logic [15:0] OP_DIV_SINIT = 16'h2007;
  localparam logic [15:0] OP_DIV_UINIT = 16'h0019;
  localparam logic [15:0] OP_DIV_STEP  = 16'h3004;

  localparam logic [XLEN-1:0] PC_STEP  = 32'h0000_0002;
  localparam logic [XLEN-1:0] PC_RESET = 32'h0000_0000;
  localparam logic [XLEN-1:0] REG_RESET = 32'h0000_0000;

  typedef enum logic [3:0] {
    flag_clear_op, compare_equal_op, compare_signed_ge_op, compare_signed_gt_op,
    compare_unsigned_gt_op, compare_unsigned_ge_op, compare_positive_op,
    compare_nonnegative_op, compare_byte_match_op, compare_imm_equal_op,
    signed_divide_init_op, unsigned_divide_init_op, divide_step_op, unknown_op
  } op_t;

  // external register load port
  typedef struct packed {
    logic              en;
    logic [RIDX_W-1:0] idx;
    logic [XLEN-1:0]   data;
  } reg_wr_t;

  // architectural flags
  typedef struct packed {
    logic t;
    logic q;
    logic m;
  } flags_t;

  typedef struct packed {
    logic [NREGS-1:0][XLEN-1:0] regs;
    flags_t                     flags;
    logic [XLEN-1:0]            pc;
    logic [XLEN-1:0]            rd_data;
    logic                       done;
    logic                       bad_op;
  } state_t;

endpackage : alu_pkg

// ---- core/divide_step_unit.sv ----
// one non-restoring divide step: shift, add or subtract, new quotient sign and flag
module divide_step_unit
  import alu_pkg::*;
(
  input  wire logic [XLEN-1:0] dividend,
  input  wire logic [XLEN-1:0] divisor,
  input  wire flags_t          flags_in,
  output logic      [XLEN-1:0] dividend_nxt,
  output flags_t               flags_nxt
);

  logic            q_top;
  logic [XLEN-1:0] shifted;
  logic [XLEN:0]   sum;

  always_comb begin
    q_top   = dividend[XLEN-1];
    shifted = {dividend[XLEN-2:0], flags_in.t};
    if (flags_in.q == flags_in.m) begin
      sum = {1'b0, shifted} - {1'b0, divisor};
    end else begin
      sum = {1'b0, shifted} + {1'b0, divisor};
    end
    dividend_nxt = sum[XLEN-1:0];
    // borrow/carry folded with the shifted-out bit and the divisor sign covers all four cases
    flags_nxt.q  = q_top ^ sum[XLEN] ^ flags_in.m;
    flags_nxt.m  = flags_in.m;
    flags_nxt.t  = (flags_nxt.q == flags_in.m);
  end

endmodule : divide_step_unit

// ---- sim/alu_asserts.sv ----
// concurrent checks on the ports of the compare and divide-step slice
module alu_asserts
  import alu_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              resetn,
  input wire logic              insn_valid,
  input wire logic [15:0]       insn,
  input wire logic [XLEN-1:0]   pc,
  input wire logic              t_flag,
  input wire logic              q_bit,
  input wire logic              m_bit,
  input wire logic              insn_done,
  input wire logic              insn_bad
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire sinit = insn_valid && ((insn & MASK_RR) == OP_DIV_SINIT);
  wire dstep = insn_valid && ((insn & MASK_RR) == OP_DIV_STEP);
  a_flag_clear: assert property (insn_valid && insn == OP_FLAG_CLR |=> !t_flag && insn_done)
    else $error("flag clear left flag set");
  a_pc_advance: assert property (insn_done |-> pc == $past(pc) + PC_STEP)
    else $error("pc did not advance by two");
  a_bad_quiet: assert property (insn_bad |-> pc == $past(pc) && t_flag == $past(t_flag))
    else $error("refused word changed state");
  a_one_answer: assert property (insn_valid |=> insn_done ^ insn_bad)
    else $error("no single answer one cycle after issue");
  a_uinit_zero: assert property (insn_valid && insn == OP_DIV_UINIT |=> !t_flag && !q_bit && !m_bit)
    else $error("unsigned init left a bit set");
  a_sinit_xor: assert property (sinit |=> t_flag == (q_bit ^ m_bit))
    else $error("signed init flag is not the sign xor");
  a_step_flag: assert property (dstep |=> t_flag == (q_bit == m_bit) && m_bit == $past(m_bit))
    else $error("divide step flag or divisor sign wrong");
  a_idle_hold: assert property (!insn_valid |=> $stable({t_flag, q_bit, m_bit, pc}) && !insn_done)
    else $error("state moved with no instruction");
  c_step: cover property (dstep ##1 dstep);
  c_bad: cover property (insn_bad);
  c_clear: cover property (t_flag ##1 !t_flag);
endmodule : alu_asserts
bind compare_divstep_alu alu_asserts chk (.ref_clk(ref_clk), .resetn(resetn), .insn_valid(insn_valid),
  .insn(insn), .pc(pc), .t_flag(t_flag), .q_bit(q_bit), .m_bit(m_bit), .insn_done(insn_done), .insn_bad(insn_bad));

// ---- sim/tb.sv ----
// self-checking bench for the compare and divide-step slice
module tb
  import alu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              ref_clk = 0, resetn = 0, insn_valid = 0, t_flag, q_bit, m_bit, insn_done, insn_bad;
  logic              mq, mm, mt;
  logic [15:0]       insn = 16'h0000;
  reg_wr_t           reg_wr = '0;
  logic [RIDX_W-1:0] rd_idx = 4'h0;
  logic [XLEN-1:0]   rd_data, pc, r, exp_pc = 32'h0;
  int                errors = 0, num_checks = 0, cycles = 0;
  localparam logic [15:0] OPS [11] = '{OP_CMP_SGE | 16'h0340, OP_CMP_UGE | 16'h0340, OP_CMP_SGT | 16'h0340,
    OP_CMP_SGE | 16'h0340, OP_CMP_UGT | 16'h0340, OP_COMPARE_EQUAL_OP | 16'h0340, OP_CMP_BYTE | 16'h0340,
    OP_CMP_BYTE | 16'h0340, OP_CMP_POS | 16'h0300, OP_CMP_NNEG | 16'h0300, 16'h8880};
  localparam logic [31:0] AV [11] = '{32'h8000_0000, 32'h8000_0000, 32'h12, 32'h12, 32'hffff_ffff, 32'h1,
    32'h4142_4344, 32'h1122_3344, 32'h0, 32'h0, 32'hffff_ff80};
  localparam logic [31:0] BV [11] = '{32'h7fff_ffff, 32'h7fff_ffff, 32'h12, 32'h12, 32'h1, 32'h2,
    32'h5859_4359, 32'h2233_4455, 32'h5, 32'h5, 32'h0};
  localparam logic [10:0] EX = 11'h2d3;

  compare_divstep_alu dut (.ref_clk(ref_clk), .resetn(resetn), .insn_valid(insn_valid), .insn(insn),
    .reg_wr(reg_wr), .rd_idx(rd_idx), .rd_data(rd_data), .pc(pc), .t_flag(t_flag), .q_bit(q_bit),
    .m_bit(m_bit), .insn_done(insn_done), .insn_bad(insn_bad));

  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task tally_and_finish();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task load(input logic [3:0] i, input logic [31:0] d);
    @(posedge ref_clk) reg_wr <= '{en: 1'b1, idx: i, data: d};
    @(posedge ref_clk) reg_wr.en <= 1'b0;
  endtask : load
  task rd(input logic [3:0] i, input logic [31:0] e);
    @(posedge ref_clk) rd_idx <= i;
    @(posedge ref_clk) #1 check("reg", e, rd_data);
  endtask : rd
  task exec(input logic [15:0] w, input logic ok);
    @(posedge ref_clk) begin insn_valid <= 1'b1; insn <= w; end
    @(posedge ref_clk) insn_valid <= 1'b0;
    #1 if (ok) exp_pc += PC_STEP;
    check("done", ok, insn_done);
    check("pc", exp_pc, pc);
  endtask : exec
  // reference step case by case: subtract when the old sign matches the divisor sign, else add;
  // the new sign is the borrow or carry when the shifted-out bit matches the divisor sign, else its inverse
  task mstep(input logic [31:0] rm);
    logic        oq;
    logic        c;
    logic [31:0] s;
    oq = mq;
    mq = r[31];
    s = {r[30:0], mt};
    if (oq == mm) begin
      r = s - rm;
      c = (r > s);
    end else begin
      r = s + rm;
      c = (r < s);
    end
    mq = (mq == mm) ? c : ~c;
    mt = (mq == mm);
  endtask : mstep
  //////////////////////////////////////////////////////////////////////////////
  task t_clear();
    load(4'h1, 32'h5); load(4'h2, 32'h5);
    exec(16'h3120, 1'b1); check("t", 1, t_flag);
    exec(OP_FLAG_CLR, 1'b1); check("t", 0, t_flag);
    rd(4'h1, 32'h5);
  endtask : t_clear
  task t_compares();
    for (int k = 0; k < 11; k++) begin
      load(4'h3, AV[k]); load(4'h4, BV[k]); load(4'h0, AV[k]);
      exec(16'h3440, 1'b1); // flag forced high so a failing compare must clear it
      exec(OPS[k], 1'b1);
      check("t", EX[10-k], t_flag);
      rd(4'h3, AV[k]);
    end
  endtask : t_compares
  task t_divide(input logic [15:0] init, input logic [31:0] dvd, input logic [31:0] dsr, input int n);
    load(4'h1, dvd); load(4'h0, dsr);
    exec(init, 1'b1);
    mq = (init == OP_DIV_UINIT) ? 1'b0 : dvd[31];
    mm = (init == OP_DIV_UINIT) ? 1'b0 : dsr[31];
    mt = mq ^ mm;
    r = dvd;
    check("qm", {mq, mm, mt}, {q_bit, m_bit, t_flag});
    repeat (n) begin
      exec(OP_DIV_STEP | 16'h0100, 1'b1); mstep(dsr);
      check("qt", {mq, mt}, {q_bit, t_flag});
    end
    rd(4'h1, r);
  endtask : t_divide
  // double-word dividend: high word in r1, low word held by the bench and rotated in ahead of every step
  task t_divide_long(input logic [31:0] hi, input logic [31:0] lo, input logic [31:0] dsr);
    logic [31:0] qw;
    logic [63:0] full;
    logic        nt;
    full = {hi, lo} / {32'h0, dsr};
    qw = lo;
    load(4'h1, hi);
    load(4'h0, dsr);
    exec(OP_DIV_UINIT, 1'b1);
    mq = 1'b0;
    mm = 1'b0;
    mt = 1'b0;
    r = hi;
    repeat (32) begin
      nt = qw[31];
      qw = {qw[30:0], t_flag};
      mt = nt;
      exec(nt ? 16'h3550 : OP_FLAG_CLR, 1'b1);
      check("rotated flag", nt, t_flag);
      exec(OP_DIV_STEP | 16'h0100, 1'b1);
      mstep(dsr);
      check("qt", {mq, mt}, {q_bit, t_flag});
    end
    qw = {qw[30:0], t_flag};
    check("quotient", full[31:0], qw);
    rd(4'h1, r);
  endtask : t_divide_long
  task t_bad();
    exec(16'hffff, 1'b0); check("bad", 1, insn_bad);
  endtask : t_bad
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    t_clear();
    t_compares();
    t_divide(OP_DIV_SINIT | 16'h0100, 32'hffff_fb2e, 32'hfffd_0000, 16);
    t_divide(OP_DIV_UINIT, 32'h0000_1234, 32'h0056_0000, 16);
    t_divide(OP_DIV_UINIT, 32'h0000_00ff, 32'h0, 4);
    // divisor nonzero and above the high word, so the quotient fits one word
    t_divide_long(32'h0000_0012, 32'h3456_789a, 32'h0000_1234);
    t_bad();
    tally_and_finish();
  end
endmodule : tb
